// ### include/qpio_pkg.sv
// Purpose: constants for the four-port i/o block with external bus
// Assumes: one clock, ports are 8 bits wide
// Notes:   latch reset values and strong-drive length live here
`default_nettype none
package qpio_pkg;
    localparam int unsigned PORT_W          = 8;
    localparam logic [7:0]  LATCH_RST       = 8'hff;
    // strong high-side drive after a written one, in clock periods
    localparam int unsigned STRONG_PERIODS  = 2;
    localparam logic [1:0]  STRONG_CNT      = 2'(STRONG_PERIODS);
    // alternate function bit positions on the fourth port
    localparam int unsigned P4_RXD          = 0;
    localparam int unsigned P4_TXD          = 1;
    localparam int unsigned P4_IRQ0         = 2;
    localparam int unsigned P4_IRQ1         = 3;
    localparam int unsigned P4_CNT0         = 4;
    localparam int unsigned P4_CNT1         = 5;
    localparam int unsigned P4_WR           = 6;
    localparam int unsigned P4_RD           = 7;
    // alternate function bit positions on the second port
    localparam int unsigned P2_TCLK         = 0;
    localparam int unsigned P2_TCTL         = 1;
    typedef enum logic [1:0] {
        QP_BUS_IDLE,
        QP_BUS_ADDR,
        QP_BUS_DATA
    } qp_bus_t;
endpackage : qpio_pkg
`default_nettype wire

// ### hw/qpio_ports.sv
// Purpose: four 8-bit i/o ports with multiplexed external memory bus
// Assumes: core supplies latch writes and bus requests, pins synchronous
// Notes:   pins are in/out/oe triples, plus a pull-up enable on ports two to four; pull-ups are outside the design
//
// Contract
// - first port: eight open-drain bidirectional pins, no pull-up.
// - a one in a first-port latch bit floats that pin for input.
// - first port carries low address then data on external accesses.
// - second port: a one written over a zero gives two clocks strong drive, then weak.
// - second port bit 0: third timer count input or clock output.
// - second port bit 1: third timer external control input.
// - third port: pulled-up, drives high address byte on external access.
// - fourth port: same weak pull-up scheme, carries special functions.
// - fourth port bits 0,1: serial receive input, serial transmit output.
// - fourth port bits 2,3: the two external interrupt inputs.
// - fourth port bits 4,5: first and second timer count inputs.
// - fourth port bits 6,7: active-low write and read strobes.
// - address latch pulse marks low address on the first port.
`default_nettype none
module qpio_ports
    import qpio_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // latch writes from the core, one strobe per port
    input  wire logic        p1_wr,
    input  wire logic        p2_wr,
    input  wire logic        p3_wr,
    input  wire logic        p4_wr,
    input  wire logic [7:0]  wr_data,
    // latch and pin views back to the core
    output logic      [7:0]  p1_latch,
    output logic      [7:0]  p2_latch,
    output logic      [7:0]  p3_latch,
    output logic      [7:0]  p4_latch,
    output logic      [7:0]  p1_pins,
    output logic      [7:0]  p2_pins,
    output logic      [7:0]  p3_pins,
    output logic      [7:0]  p4_pins,
    // external memory access request: start pulse, write flag
    input  wire logic        ext_start,
    input  wire logic        ext_write,
    input  wire logic [15:0] ext_addr,
    input  wire logic [7:0]  ext_wdata,
    output logic      [7:0]  ext_rdata,
    output logic             ext_done,
    output logic             ext_busy,
    output logic             addr_latch_pulse,
    // alternate functions
    input  wire logic        timer_three_clk_out_en,
    input  wire logic        timer_three_clk_out,
    output logic             timer_three_ext_clock_pin,
    output logic             timer_three_ext_control_pin,
    input  wire logic        serial_tx,
    output logic             serial_rx,
    output logic             ext_irq_zero_pin,
    output logic             ext_irq_one_pin,
    output logic             timer_one_count_pin,
    output logic             timer_two_count_pin,
    // first port pins (open drain)
    input  wire logic [7:0]  p1_in,
    output logic      [7:0]  p1_out,
    output logic      [7:0]  p1_oe,
    // second port pins: strong drive and weak pull-up enable
    input  wire logic [7:0]  p2_in,
    output logic      [7:0]  p2_out,
    output logic      [7:0]  p2_oe,
    output logic      [7:0]  p2_pu,
    // third port pins
    input  wire logic [7:0]  p3_in,
    output logic      [7:0]  p3_out,
    output logic      [7:0]  p3_oe,
    output logic      [7:0]  p3_pu,
    // fourth port pins
    input  wire logic [7:0]  p4_in,
    output logic      [7:0]  p4_out,
    output logic      [7:0]  p4_oe,
    output logic      [7:0]  p4_pu
);

    typedef struct packed {
        logic [7:0]  l1;
        logic [7:0]  l2;
        logic [7:0]  l3;
        logic [7:0]  l4;
        logic [15:0] s2;
        logic [15:0] s3;
        logic [15:0] s4;
        logic [7:0]  lat3;
        logic [7:0]  lat4;
        qp_bus_t     bus;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdat;
        logic [7:0]  rdat;
        logic        done;
    } qp_state_t;

    qp_state_t st_r;
    qp_state_t st_nxt;

    // per-bit two-period strong drive counters for a pulled-up port
    function automatic logic [15:0] qp_strong(input logic [15:0] cnt,
                                              input logic [7:0]  old,
                                              input logic [7:0]  nw,
                                              input logic        wr,
                                              input logic [1:0]  ld);
        logic [15:0] res;
        res = '0;
        for (int i = 0; i < PORT_W; i++) begin
            if (wr && nw[i] && !old[i]) begin
                res[2*i +: 2] = ld;
            end else if (cnt[2*i +: 2] != 2'h0) begin
                res[2*i +: 2] = cnt[2*i +: 2] - 2'h1;
            end
        end
        return res;
    endfunction : qp_strong

    function automatic logic [7:0] qp_active(input logic [15:0] cnt);
        logic [7:0] res;
        res = '0;
        for (int i = 0; i < PORT_W; i++) begin
            res[i] = cnt[2*i +: 2] != 2'h0;
        end
        return res;
    endfunction : qp_active

    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (p1_wr) st_nxt.l1 = wr_data;
        if (p2_wr) st_nxt.l2 = wr_data;
        if (p3_wr) st_nxt.l3 = wr_data;
        if (p4_wr) st_nxt.l4 = wr_data;
        // strong drive also fires when an alternate output rises, on the third and fourth ports only
        st_nxt.s2 = qp_strong(st_r.s2, st_r.l2, wr_data, p2_wr,
                              STRONG_CNT);
        // rise cycle is the first strong period, counter gives the rest
        st_nxt.s3 = qp_strong(st_r.s3, st_r.lat3, p3_out,
                              1'b1, STRONG_CNT - 2'h1);
        st_nxt.s4 = qp_strong(st_r.s4, st_r.lat4, p4_out,
                              1'b1, STRONG_CNT - 2'h1);
        st_nxt.lat3 = p3_out;
        st_nxt.lat4 = p4_out;
        unique case (st_r.bus)
            QP_BUS_IDLE: begin
                if (ext_start) begin
                    st_nxt.bus  = QP_BUS_ADDR;
                    st_nxt.wr   = ext_write;
                    st_nxt.addr = ext_addr;
                    st_nxt.wdat = ext_wdata;
                end
            end
            QP_BUS_ADDR: begin
                st_nxt.bus = QP_BUS_DATA;
            end
            QP_BUS_DATA: begin
                if (!st_r.wr) st_nxt.rdat = p1_in;
                st_nxt.done = 1'b1;
                st_nxt.bus  = QP_BUS_IDLE;
            end
        endcase
        // second-port strong drive only on a written one, in any bus state
        if (!p2_wr) begin
            st_nxt.s2 = qp_strong(st_r.s2, st_r.l2, st_r.l2, 1'b0,
                                  STRONG_CNT);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r      <= '0;
            st_r.l1   <= LATCH_RST;
            st_r.l2   <= LATCH_RST;
            st_r.l3   <= LATCH_RST;
            st_r.l4   <= LATCH_RST;
            st_r.lat3 <= LATCH_RST;
            st_r.lat4 <= LATCH_RST;
            st_r.bus  <= QP_BUS_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    logic       in_bus;
    logic [7:0] p4_alt;

    assign in_bus   = st_r.bus != QP_BUS_IDLE;
    assign ext_busy = in_bus;
    assign ext_done = st_r.done;
    assign ext_rdata        = st_r.rdat;
    assign addr_latch_pulse = st_r.bus == QP_BUS_ADDR;

    // first port: drive low for zeros, float for ones
    always_comb begin
        p1_out = 8'h00;
        p1_oe  = ~st_r.l1;
        if (st_r.bus == QP_BUS_ADDR) begin
            p1_out = st_r.addr[7:0];
            p1_oe  = 8'hff;
        end else if (st_r.bus == QP_BUS_DATA) begin
            p1_out = st_r.wdat;
            p1_oe  = st_r.wr ? 8'hff : 8'h00;
        end
    end

    // second port with timer three clock output on bit 0
    always_comb begin
        p2_out = st_r.l2;
        if (timer_three_clk_out_en) begin
            p2_out[P2_TCLK] = timer_three_clk_out;
        end
        p2_oe = ~p2_out | qp_active(st_r.s2);
        p2_pu = 8'hff;
    end

    // third port: high address byte during external access
    always_comb begin
        p3_out = in_bus ? st_r.addr[15:8] : st_r.l3;
    end
    assign p3_oe = ~p3_out | ~st_r.lat3 | qp_active(st_r.s3);
    assign p3_pu = 8'hff;

    // fourth port alternate outputs are active-low or idle high
    always_comb begin
        p4_alt         = 8'hff;
        p4_alt[P4_TXD] = serial_tx;
        p4_alt[P4_WR]  = !(st_r.bus == QP_BUS_DATA && st_r.wr);
        p4_alt[P4_RD]  = !(st_r.bus == QP_BUS_DATA && !st_r.wr);
        p4_out = st_r.l4 & p4_alt;
    end
    assign p4_oe = ~p4_out | ~st_r.lat4 | qp_active(st_r.s4);
    assign p4_pu = 8'hff;

    assign serial_rx                   = p4_in[P4_RXD];
    assign ext_irq_zero_pin            = p4_in[P4_IRQ0];
    assign ext_irq_one_pin             = p4_in[P4_IRQ1];
    assign timer_one_count_pin         = p4_in[P4_CNT0];
    assign timer_two_count_pin         = p4_in[P4_CNT1];
    assign timer_three_ext_clock_pin   = p2_in[P2_TCLK];
    assign timer_three_ext_control_pin = p2_in[P2_TCTL];

    assign p1_latch = st_r.l1;
    assign p2_latch = st_r.l2;
    assign p3_latch = st_r.l3;
    assign p4_latch = st_r.l4;
    assign p1_pins  = p1_in;
    assign p2_pins  = p2_in;
    assign p3_pins  = p3_in;
    assign p4_pins  = p4_in;

endmodule : qpio_ports
`default_nettype wire

// ### verification/qpio_props.sv
// Purpose: bus and port checks on qpio_ports
// Assumes: bound into qpio_ports
// Notes:   one clock, async active-low reset
`default_nettype none
module qpio_props (
    // clock, reset, latch writes
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        p2_wr,
    input wire logic [7:0]  wr_data,
    // ports
    input wire logic [7:0]  p1_latch,
    input wire logic [7:0]  p2_latch,
    input wire logic [7:0]  p3_latch,
    input wire logic [7:0]  p4_latch,
    input wire logic [7:0]  p1_out,
    input wire logic [7:0]  p1_oe,
    input wire logic [7:0]  p2_oe,
    input wire logic [7:0]  p2_out,
    input wire logic        timer_three_clk_out_en,
    input wire logic        timer_three_clk_out,
    input wire logic        serial_tx,
    input wire logic [7:0]  p3_out,
    input wire logic [7:0]  p4_out,
    input wire logic [7:0]  p4_in,
    input wire logic        serial_rx,
    // external bus
    input wire logic        ext_start,
    input wire logic        ext_write,
    input wire logic [15:0] ext_addr,
    input wire logic        ext_busy,
    input wire logic        ext_done,
    input wire logic        addr_latch_pulse
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] hi_r;
    logic       go;
    assign go = ext_start && !ext_busy;
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n) hi_r <= 8'h00;
        else if (go) hi_r <= ext_addr[15:8];
    property p_open_drain;
        !ext_busy && !ext_done |->
            p1_oe == ~p1_latch && (p1_out & p1_oe) == 8'h00;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("p1 drive");
    property p_seq;
        go |=> addr_latch_pulse ##1 !addr_latch_pulse && ext_busy ##1 ext_done;
    endproperty
    a_seq: assert property (p_seq) else $error("bus sequence");
    property p_wr_strb;
        go && ext_write && p4_latch[7] |-> ##2 !p4_out[6] && p4_out[7];
    endproperty
    a_wr_strb: assert property (p_wr_strb) else $error("write strobe");
    property p_rd_strb;
        go && !ext_write && p4_latch[6] |-> ##2 !p4_out[7] && p4_out[6];
    endproperty
    a_rd_strb: assert property (p_rd_strb) else $error("read strobe");
    property p_strong;
        p2_wr && p2_latch == 8'h00 && wr_data == 8'hff |=>
            p2_oe == 8'hff [*2] ##1 p2_oe == 8'h00;
    endproperty
    a_strong: assert property (p_strong) else $error("strong drive");
    property p_rst;
        $rose(rst_n) |-> (p1_latch & p2_latch & p3_latch & p4_latch) == 8'hff;
    endproperty
    a_rst: assert property (p_rst) else $error("latch reset");
    property p_high;
        addr_latch_pulse |-> p3_out == hi_r;
    endproperty
    a_high: assert property (p_high) else $error("high address");
    property p_rx;
        serial_rx == p4_in[0];
    endproperty
    a_rx: assert property (p_rx) else $error("serial receive");
    property p_clk_out;
        timer_three_clk_out_en |-> p2_out[0] == timer_three_clk_out;
    endproperty
    a_clk_out: assert property (p_clk_out) else $error("clock out");
    property p_tx;
        p4_latch[1] |-> p4_out[1] == serial_tx;
    endproperty
    a_tx: assert property (p_tx) else $error("serial transmit");
endmodule : qpio_props
bind qpio_ports qpio_props i_props (.*);
`default_nettype wire

// ### verification/qpio_mem_model.sv
// Purpose: external memory on the multiplexed bus
// Assumes: board pull-ups on the open-drain low bus
// Notes:   256 bytes, index folds both address bytes
`default_nettype none
module qpio_mem_model (
    // clock and device pins
    input  wire logic       core_clk,
    input  wire logic       addr_latch_pulse,
    input  wire logic [7:0] p1_out,
    input  wire logic [7:0] p1_oe,
    input  wire logic [7:0] p3_out,
    input  wire logic [7:0] p4_out,
    // low bus level seen by the device
    output logic      [7:0] p1_in
);
    logic [7:0] mem [256];
    logic [7:0] idx_r = 8'h00;
    // driven zeros win; data only while read strobe is low
    assign p1_in = (p4_out[7] ? 8'hff : mem[idx_r]) & ~(p1_oe & ~p1_out);
    always @(posedge core_clk) begin
        if (addr_latch_pulse) idx_r <= p1_in ^ p3_out;
        if (!p4_out[6]) mem[idx_r] <= p1_in;
    end
endmodule : qpio_mem_model
`default_nettype wire

// ### verification/tb_top.sv
// Purpose: self-checking bench for qpio_ports
// Assumes: 125 MHz clock, memory model on the low bus
// Notes:   seeded random latch, pin and bus traffic
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rst_n = 1'b0, ext_start, ext_write, serial_tx;
    logic p1_wr, p2_wr, p3_wr, p4_wr, timer_three_clk_out_en;
    logic timer_three_clk_out, ext_done, ext_busy, addr_latch_pulse;
    logic timer_three_ext_clock_pin, timer_three_ext_control_pin, serial_rx;
    logic ext_irq_zero_pin, ext_irq_one_pin;
    logic timer_one_count_pin, timer_two_count_pin;
    logic [7:0] wr_data, ext_wdata, p1_in, p2_in, p3_in, p4_in, ext_rdata;
    logic [7:0] p1_latch, p2_latch, p3_latch, p4_latch, p1_pins, p2_pins;
    logic [7:0] p3_pins, p4_pins, p1_out, p1_oe, p2_out, p2_oe, p2_pu;
    logic [7:0] p3_out, p3_oe, p3_pu, p4_out, p4_oe, p4_pu;
    logic [15:0] ext_addr;
    logic [31:0] lat, oes;
    int          fails = 0, n_compared = 0;
    assign lat = {p4_latch, p3_latch, p2_latch, p1_latch};
    assign oes = {p4_oe, p3_oe, p2_oe, p1_oe};
    qpio_ports i_qpio_ports (.*);
    qpio_mem_model i_qpio_mem_model (.*);
    always #4 core_clk = ~core_clk;
    function automatic logic [7:0] pick(input int p, input logic [31:0] v);
        return v[8*(p-1) +: 8];
    endfunction : pick
    function automatic logic [7:0] alt_exp(input logic [7:0] a, b);
        return {b[5:2], b[0], a[1:0], 1'b0};
    endfunction : alt_exp
    task chk(input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: expected %h got %h", $time, e, g);
        end
    endtask : chk
    task finish_test;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test
    task step;
        @(posedge core_clk);
        #1;
    endtask : step
    task wr(input int p, input logic [7:0] d);
        @(posedge core_clk);
        {p4_wr, p3_wr, p2_wr, p1_wr} <= 4'(1 << (p - 1));
        wr_data <= d;
        step();
        {p4_wr, p3_wr, p2_wr, p1_wr} <= 4'h0;
    endtask : wr
    task ext(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        {ext_start, ext_write, ext_addr, ext_wdata} <= {1'b1, w, a, d};
        @(posedge core_clk);
        ext_start <= 1'b0;
        do begin
            step();
            n++;
        end while (ext_done !== 1'b1 && n < 8);
        chk(8'd2, 8'(n));
    endtask : ext
    task chk_rst;
        for (int p = 1; p <= 4; p++) chk(8'hff, pick(p, lat));
        chk(8'h00, p1_oe);
        chk(8'hff, p2_pu & p3_pu & p4_pu);
    endtask : chk_rst
    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        finish_test();
    end
    initial begin
        logic [7:0]  d, a2, a3, a4;
        logic [15:0] a;
        int          p;
        {p1_wr, p2_wr, p3_wr, p4_wr, ext_start, ext_write} = '0;
        {timer_three_clk_out_en, timer_three_clk_out, serial_tx} = 3'b001;
        {wr_data, ext_wdata, ext_addr} = '0;
        {p2_in, p3_in, p4_in} = '1;
        d = 8'($urandom(32'h168a));
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        step();
        chk_rst();
        for (p = 2; p <= 4; p++) begin
            wr(p, 8'h00);
            wr(p, 8'hff);
            chk(8'hff, pick(p, oes));
            step();
            chk(8'hff, pick(p, oes));
            step();
            chk(8'h00, pick(p, oes));
        end
        repeat (40) begin
            p = $urandom_range(4, 1);
            {d, a2, a3, a4} = $urandom;
            @(posedge core_clk);
            {p2_in, p3_in, p4_in, serial_tx} <= {a2, a3, a4, d[0]};
            wr(p, d);
            chk(a2, p2_pins);
            chk(a3, p3_pins);
            chk(a4, p4_pins);
            chk(d, pick(p, lat));
            if (p == 1) chk(~d, p1_oe);
            chk(alt_exp(a2, a4), {timer_two_count_pin, timer_one_count_pin,
                ext_irq_one_pin, ext_irq_zero_pin, serial_rx,
                timer_three_ext_control_pin, timer_three_ext_clock_pin,
                1'b0});
        end
        wr(1, 8'hff);
        wr(4, 8'hff);
        for (int i = 0; i < 12; i++) begin
            a = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom);
            d = 8'($urandom);
            ext(1'b1, a, d);
            ext(1'b0, a, 8'h00);
            chk(d, ext_rdata);
            chk(8'hff, p1_pins);
        end
        wr(2, 8'h00);
        for (int i = 0; i < 8; i++) begin
            d = 8'(i);
            @(posedge core_clk);
            {timer_three_clk_out_en, timer_three_clk_out, serial_tx} <= d[2:0];
            step();
            chk({7'h00, d[2] & d[1]}, {7'h00, p2_out[0]});
            chk({7'h00, d[0]}, {7'h00, p4_out[1]});
        end
        wr(3, 8'h00);
        @(posedge core_clk);
        rst_n <= 1'b0;
        @(posedge core_clk);
        rst_n <= 1'b1;
        step();
        chk_rst();
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
